//--- hdl/sesc_pin_sync.sv
// Three-stage synchroniser for the hardware enable pin
`timescale 1ns/1ps
module sesc_pin_sync #(
    parameter int STAGES = 3
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic pin_in,
    output logic pin_out
);
    logic [STAGES-1:0] sync_reg;
    logic level_reg;
    // Shift chain; first stage read only by the second
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= {sync_reg[STAGES-2:0], pin_in};
        end
    end
    // Accept a change only once the last two stages agree
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            level_reg <= 1'b0;
        end else if (sync_reg[STAGES-1] == sync_reg[STAGES-2]) begin
            level_reg <= sync_reg[STAGES-1];
        end
    end
    assign pin_out = level_reg;
endmodule : sesc_pin_sync

//--- hdl/sesc_top.sv
// Supply enable source select, enable delay and soft start / soft stop sequencer
// Notes on behaviour
// - Bits 7:6 choose enable source; 00 always on
// - Code 01: hardware pin alone enables supply
// - Code 10: software bit 5 alone enables
// - Code 11: pin and software bit both needed
// - Delay field gives 0, 0.5, 1, 2 s
// - Soft stop applies to every shutdown, faults too
// - Ramp-down lasts the programmed soft-start time
// - Without soft stop, outputs cut off at once
// - Ramp field: 360 us, 10, 20, 40 ms
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module sesc_top #(
    parameter longint DLY_1_CYC = sesc_pkg::SESC_DLY_1_CYC,
    parameter longint DLY_2_CYC = sesc_pkg::SESC_DLY_2_CYC,
    parameter longint DLY_3_CYC = sesc_pkg::SESC_DLY_3_CYC,
    parameter longint RAMP_0_CYC = sesc_pkg::SESC_RAMP_0_CYC,
    parameter longint RAMP_1_CYC = sesc_pkg::SESC_RAMP_1_CYC,
    parameter longint RAMP_2_CYC = sesc_pkg::SESC_RAMP_2_CYC,
    parameter longint RAMP_3_CYC = sesc_pkg::SESC_RAMP_3_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic hardware_enable_pin,
    input wire logic fault_shutdown,
    output logic pwm_enable,
    output logic ramp_up,
    output logic ramp_down,
    output logic supply_running
);
    localparam int W = sesc_pkg::SESC_CNT_W;

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    logic pin_level;
    sesc_pin_sync #(.STAGES(sesc_pkg::SESC_SYNC_STAGES)) u_pin_sync (
        .clock(clock),
        .resetn(resetn),
        .pin_in(hardware_enable_pin),
        .pin_out(pin_level)
    );

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    logic [7:0] cfg_reg;
    logic [7:0] rdata_reg;
    sesc_pkg::sesc_state_t state_reg, state_next;
    wire cfg_hit = reg_addr == sesc_pkg::SESC_CFG_ADDR;
    wire status_hit = reg_addr == sesc_pkg::SESC_STATUS_ADDR;
    wire [7:0] status_word = {3'h0, pin_level, 1'b0, state_reg};
    wire [7:0] rd_mux = cfg_hit ? cfg_reg : (status_hit ? status_word : 8'h00);
    // Config write; unmapped writes are dropped
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_reg <= sesc_pkg::SESC_CFG_RESET;
        end else if (reg_wr && cfg_hit) begin
            cfg_reg <= reg_wdata;
        end
    end
    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // Effective enable selection
    // ----------------------------------------
    wire [1:0] src_sel = cfg_reg[sesc_pkg::SESC_SRC_HI:sesc_pkg::SESC_SRC_LO];
    wire sw_en = cfg_reg[sesc_pkg::SESC_SW_EN_BIT];
    wire [1:0] dly_sel = cfg_reg[sesc_pkg::SESC_DLY_HI:sesc_pkg::SESC_DLY_LO];
    wire soft_stop_en = cfg_reg[sesc_pkg::SESC_SOFT_STOP_BIT];
    wire [1:0] ramp_sel = cfg_reg[sesc_pkg::SESC_RAMP_HI:sesc_pkg::SESC_RAMP_LO];
    wire en_always = src_sel == sesc_pkg::SESC_SRC_ALWAYS;
    wire en_pin = (src_sel == sesc_pkg::SESC_SRC_PIN) && pin_level;
    wire en_sw = (src_sel == sesc_pkg::SESC_SRC_SW) && sw_en;
    wire en_both = (src_sel == sesc_pkg::SESC_SRC_BOTH) && sw_en && pin_level;
    // A fault forces shutdown regardless of source
    wire eff_enable = (en_always || en_pin || en_sw || en_both) && !fault_shutdown;

    // ----------------------------------------
    // Delay and ramp lengths
    // ----------------------------------------
    // Delay code 00 means soft start begins on the second edge after enable, after one cycle in WAIT
    wire [W-1:0] dly_cycles = (dly_sel == 2'h1) ? W'(DLY_1_CYC) :
                              (dly_sel == 2'h2) ? W'(DLY_2_CYC) :
                              (dly_sel == 2'h3) ? W'(DLY_3_CYC) : W'(0);
    wire [W-1:0] ramp_cycles = (ramp_sel == 2'h1) ? W'(RAMP_1_CYC) :
                               (ramp_sel == 2'h2) ? W'(RAMP_2_CYC) :
                               (ramp_sel == 2'h3) ? W'(RAMP_3_CYC) : W'(RAMP_0_CYC);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic [W-1:0] cnt_reg, cnt_next;
    wire cnt_done = cnt_reg >= dly_cycles;
    wire ramp_done = cnt_reg + W'(1) >= ramp_cycles;
    // Next state; ramp lengths are read live so a change mid-ramp takes effect at once
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + W'(1);
        unique case (state_reg)
            sesc_pkg::SESC_OFF: begin
                cnt_next = '0;
                if (eff_enable) begin
                    state_next = sesc_pkg::SESC_WAIT;
                end
            end
            sesc_pkg::SESC_WAIT: begin
                if (!eff_enable) begin
                    state_next = sesc_pkg::SESC_OFF;
                    cnt_next = '0;
                end else if (cnt_done) begin
                    state_next = sesc_pkg::SESC_RAMP_UP;
                    cnt_next = '0;
                end
            end
            sesc_pkg::SESC_RAMP_UP, sesc_pkg::SESC_ON: begin
                if (!eff_enable) begin
                    // Shutdown path, fault-driven ones included
                    state_next = soft_stop_en ? sesc_pkg::SESC_RAMP_DOWN : sesc_pkg::SESC_OFF;
                    cnt_next = '0;
                end else if (state_reg == sesc_pkg::SESC_RAMP_UP && ramp_done) begin
                    state_next = sesc_pkg::SESC_ON;
                    cnt_next = '0;
                end else if (state_reg == sesc_pkg::SESC_ON) begin
                    cnt_next = '0;
                end
            end
            sesc_pkg::SESC_RAMP_DOWN: begin
                // Ramp down completes even if enable returns; avoids a half-ramped restart
                if (ramp_done) begin
                    state_next = sesc_pkg::SESC_OFF;
                    cnt_next = '0;
                end
            end
            default: begin
                state_next = sesc_pkg::SESC_OFF;
                cnt_next = '0;
            end
        endcase
    end
    // State and counter
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= sesc_pkg::SESC_OFF;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // ----------------------------------------
    // Outputs from flip-flops
    // ----------------------------------------
    logic pwm_reg, up_reg, down_reg, run_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pwm_reg <= 1'b0;
            up_reg <= 1'b0;
            down_reg <= 1'b0;
            run_reg <= 1'b0;
        end else begin
            pwm_reg <= state_next inside {sesc_pkg::SESC_RAMP_UP, sesc_pkg::SESC_ON, sesc_pkg::SESC_RAMP_DOWN};
            up_reg <= state_next == sesc_pkg::SESC_RAMP_UP;
            down_reg <= state_next == sesc_pkg::SESC_RAMP_DOWN;
            run_reg <= state_next == sesc_pkg::SESC_ON;
        end
    end
    assign pwm_enable = pwm_reg;
    assign ramp_up = up_reg;
    assign ramp_down = down_reg;
    assign supply_running = run_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_hard_stop_cut: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg inside {sesc_pkg::SESC_RAMP_UP, sesc_pkg::SESC_ON}) && !eff_enable && !soft_stop_en
        |=> !pwm_enable && state_reg == sesc_pkg::SESC_OFF) else $error("hard stop did not cut outputs");
    chk_soft_stop_ramp: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg inside {sesc_pkg::SESC_RAMP_UP, sesc_pkg::SESC_ON}) && !eff_enable && soft_stop_en
        |=> ramp_down && pwm_enable) else $error("soft stop ramp missing");
    chk_down_length: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == sesc_pkg::SESC_RAMP_DOWN |-> cnt_reg < ramp_cycles) else $error("ramp down too long");
    chk_wait_cancel: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == sesc_pkg::SESC_WAIT && !eff_enable |=> state_reg == sesc_pkg::SESC_OFF)
        else $error("pending start not cancelled");
    chk_delay_min: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == sesc_pkg::SESC_WAIT && state_next == sesc_pkg::SESC_RAMP_UP |-> cnt_reg >= dly_cycles)
        else $error("soft start began early");
    chk_always_on: assert property (@(posedge clock) disable iff (!resetn)
        src_sel == sesc_pkg::SESC_SRC_ALWAYS && !fault_shutdown |-> eff_enable) else $error("always-on lost");
    chk_pin_source: assert property (@(posedge clock) disable iff (!resetn)
        src_sel == sesc_pkg::SESC_SRC_PIN && !fault_shutdown |-> eff_enable == pin_level)
        else $error("pin source wrong");
    chk_sw_source: assert property (@(posedge clock) disable iff (!resetn)
        src_sel == sesc_pkg::SESC_SRC_SW && !fault_shutdown |-> eff_enable == sw_en) else $error("sw source wrong");
    chk_both_source: assert property (@(posedge clock) disable iff (!resetn)
        src_sel == sesc_pkg::SESC_SRC_BOTH && (!sw_en || !pin_level) |-> !eff_enable) else $error("and source wrong");
    chk_ramp_length: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == sesc_pkg::SESC_RAMP_UP |-> cnt_reg < ramp_cycles) else $error("ramp up too long");
    chk_run_shutdown: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == sesc_pkg::SESC_ON && !eff_enable |=> !supply_running) else $error("no shutdown on drop");
    cov_start: cover property (@(posedge clock) disable iff (!resetn)
        state_reg == sesc_pkg::SESC_RAMP_UP ##1 state_reg == sesc_pkg::SESC_ON);
    cov_soft_stop: cover property (@(posedge clock) disable iff (!resetn)
        state_reg == sesc_pkg::SESC_RAMP_DOWN ##1 state_reg == sesc_pkg::SESC_OFF);
    cov_cancel: cover property (@(posedge clock) disable iff (!resetn)
        state_reg == sesc_pkg::SESC_WAIT ##1 state_reg == sesc_pkg::SESC_OFF);
    cov_fault_stop: cover property (@(posedge clock) disable iff (!resetn)
        state_reg == sesc_pkg::SESC_ON && fault_shutdown && soft_stop_en);
endmodule : sesc_top

//--- pkg/sesc_pkg.sv
// Package: register map, field positions and timing constants for the supply enable sequencer
package sesc_pkg;
    // Register map
    localparam logic [7:0] SESC_CFG_ADDR = 8'h2C;
    localparam logic [7:0] SESC_STATUS_ADDR = 8'h2D;
    localparam logic [7:0] SESC_CFG_RESET = 8'h00;
    // Field positions
    localparam int SESC_SRC_HI = 7;
    localparam int SESC_SRC_LO = 6;
    localparam int SESC_SW_EN_BIT = 5;
    localparam int SESC_DLY_HI = 4;
    localparam int SESC_DLY_LO = 3;
    localparam int SESC_SOFT_STOP_BIT = 2;
    localparam int SESC_RAMP_HI = 1;
    localparam int SESC_RAMP_LO = 0;
    // Enable source codes
    localparam logic [1:0] SESC_SRC_ALWAYS = 2'h0;
    localparam logic [1:0] SESC_SRC_PIN = 2'h1;
    localparam logic [1:0] SESC_SRC_SW = 2'h2;
    localparam logic [1:0] SESC_SRC_BOTH = 2'h3;
    // Clock and times
    localparam longint SESC_CLK_HZ = 25000000;
    localparam longint SESC_DLY_0_MS = 0;
    localparam longint SESC_DLY_1_MS = 500;
    localparam longint SESC_DLY_2_MS = 1000;
    localparam longint SESC_DLY_3_MS = 2000;
    localparam longint SESC_RAMP_0_US = 360;
    localparam longint SESC_RAMP_1_US = 10000;
    localparam longint SESC_RAMP_2_US = 20000;
    localparam longint SESC_RAMP_3_US = 40000;
    // Cycle counts (least times round up)
    localparam longint SESC_DLY_1_CYC = (SESC_DLY_1_MS * SESC_CLK_HZ + 999) / 1000;
    localparam longint SESC_DLY_2_CYC = (SESC_DLY_2_MS * SESC_CLK_HZ + 999) / 1000;
    localparam longint SESC_DLY_3_CYC = (SESC_DLY_3_MS * SESC_CLK_HZ + 999) / 1000;
    localparam longint SESC_RAMP_0_CYC = (SESC_RAMP_0_US * SESC_CLK_HZ + 999999) / 1000000;
    localparam longint SESC_RAMP_1_CYC = (SESC_RAMP_1_US * SESC_CLK_HZ + 999999) / 1000000;
    localparam longint SESC_RAMP_2_CYC = (SESC_RAMP_2_US * SESC_CLK_HZ + 999999) / 1000000;
    localparam longint SESC_RAMP_3_CYC = (SESC_RAMP_3_US * SESC_CLK_HZ + 999999) / 1000000;
    localparam int SESC_CNT_W = 26;
    localparam int SESC_SYNC_STAGES = 3;
    // Sequencer states
    typedef enum logic [2:0] {SESC_OFF, SESC_WAIT, SESC_RAMP_UP, SESC_ON, SESC_RAMP_DOWN} sesc_state_t;
endpackage : sesc_pkg

//--- tb/sesc_host_model.sv
// Host model that drives the hardware enable pin of the sequencer
`timescale 1ns/1ps
module sesc_host_model (
    input wire logic clock,
    input wire logic want_on,
    output logic hardware_enable_pin
);
    // ----------------------------------------
    // Pin driver
    // ----------------------------------------
    // Moves the pin only just after an edge; soft stop is chosen knowingly by the bench
    always @(posedge clock) begin
        hardware_enable_pin <= want_on;
    end
endmodule : sesc_host_model

//--- tb/supply_enable_soft_start_control_tb.sv
// Self-checking bench for the supply enable sequencer
`timescale 1ns/1ps
module supply_enable_soft_start_control_tb;
    // Short counts keep the run small; expectations use these same values
    localparam int DLY_C [4] = '{0, 20, 40, 80};
    localparam int RAMP_C [4] = '{5, 10, 20, 40};
    logic clock, resetn, reg_wr, reg_rd, want_on, pin, fault_shutdown;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg;
    logic pwm_enable, ramp_up, ramp_down, supply_running;
    logic [31:0] seed;
    int n_fail, cmp_count, n;
    // ----------------------------------------
    // Clock, partner and design
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    sesc_host_model host_u (.clock(clock), .want_on(want_on), .hardware_enable_pin(pin));
    sesc_top #(.DLY_1_CYC(DLY_C[1]), .DLY_2_CYC(DLY_C[2]), .DLY_3_CYC(DLY_C[3]), .RAMP_0_CYC(RAMP_C[0]),
        .RAMP_1_CYC(RAMP_C[1]), .RAMP_2_CYC(RAMP_C[2]), .RAMP_3_CYC(RAMP_C[3])) dut_u (.clock(clock),
        .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hardware_enable_pin(pin), .fault_shutdown(fault_shutdown), .pwm_enable(pwm_enable),
        .ramp_up(ramp_up), .ramp_down(ramp_down), .supply_running(supply_running));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Effective enable from source code, pin and software bit
    function automatic logic exp_en(input logic [1:0] src, input logic p, input logic sw);
        case (src)
            2'h0: return 1'b1;
            2'h1: return p;
            2'h2: return sw;
            default: return p & sw;
        endcase
    endfunction : exp_en
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe, then return to zero
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk(reg_rdata, exp, "read data");
        @(negedge clock);
        chk(reg_rdata, 8'h00, "read data after");
    endtask : rd
    // Counts edges until the chosen condition holds; bounded so a hang ends the run
    task automatic steps(input int which, output int cnt);
        logic hit;
        cnt = 0;
        hit = 1'b0;
        while (!hit) begin
            @(posedge clock);
            @(negedge clock);
            cnt++;
            case (which)
                0: hit = (ramp_up === 1'b1);
                1: hit = (ramp_up === 1'b0);
                2: hit = (ramp_down === 1'b1);
                default: hit = (ramp_down === 1'b0);
            endcase
            if (cnt > 3000) begin
                n_fail++;
                $display("[ERR] %0t wait bound used up", $time);
                summarize();
            end
        end
    endtask : steps
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {resetn, reg_wr, reg_rd, want_on, fault_shutdown} = 5'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        n_fail = 0;
        cmp_count = 0;
        seed = 32'hE5777609;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        rd(sesc_pkg::SESC_CFG_ADDR, sesc_pkg::SESC_CFG_RESET);
        steps(0, n);
        chk(pwm_enable, 1'b1, "always on start");
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        $display("reset and bus test done");
        // Every source code four times, pin and software bit at random
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            want_on <= seed[3];
            cfg = {i[1:0], seed[2], 5'h00};
            wr(sesc_pkg::SESC_CFG_ADDR, cfg);
            rd(sesc_pkg::SESC_CFG_ADDR, cfg);
            repeat (30) @(posedge clock);
            @(negedge clock);
            chk(supply_running, exp_en(i[1:0], seed[3], seed[2]), "source select");
        end
        $display("source test done");
        // Delay and ramp codes; soft stop by software drop or by fault
        for (int k = 0; k < 4; k++) begin
            cfg = 8'h80 | 8'(k << 3) | 8'(k);
            wr(sesc_pkg::SESC_CFG_ADDR, cfg);
            repeat (4) @(posedge clock);
            wr(sesc_pkg::SESC_CFG_ADDR, cfg | 8'h20);
            steps(0, n);
            // Enable rises one edge after the write; waiting state holds count 0 to delay
            chk(n, 2 + DLY_C[k], "delay to ramp");
            steps(1, n);
            chk(n, RAMP_C[k], "ramp up length");
            chk(supply_running, 1'b1, "running");
            wr(sesc_pkg::SESC_CFG_ADDR, cfg | 8'h24);
            if (k[0]) begin
                @(posedge clock);
                fault_shutdown <= 1'b1;
            end else begin
                wr(sesc_pkg::SESC_CFG_ADDR, cfg | 8'h04);
            end
            steps(2, n);
            chk(n, 1, "stop start");
            chk(pwm_enable, 1'b1, "switching in soft stop");
            steps(3, n);
            chk(n, RAMP_C[k], "ramp down length");
            chk(pwm_enable, 1'b0, "off after soft stop");
            fault_shutdown <= 1'b0;
            wr(sesc_pkg::SESC_CFG_ADDR, cfg);
        end
        $display("timing test done");
        // Early drop in the delay cancels; the delay runs again in full
        wr(sesc_pkg::SESC_CFG_ADDR, 8'hA8);
        repeat (10) @(posedge clock);
        wr(sesc_pkg::SESC_CFG_ADDR, 8'h88);
        wr(sesc_pkg::SESC_CFG_ADDR, 8'hA8);
        steps(0, n);
        chk(n, 2 + DLY_C[1], "restarted delay");
        // Fault with soft stop off cuts the outputs at the next edge
        steps(1, n);
        @(posedge clock);
        fault_shutdown <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        chk(pwm_enable, 1'b0, "immediate cut");
        chk(ramp_down, 1'b0, "no ramp down");
        // Status word: synchronised pin level in bit 4, state off in bits 2:0
        rd(sesc_pkg::SESC_STATUS_ADDR, {3'h0, want_on, 4'h0});
        $display("cancel and cut test done");
        summarize();
    end
endmodule : supply_enable_soft_start_control_tb
